// File: hdl/brf_core.sv
// Banked register file, status words, state and byte-lane steering
//
// Behaviour
// RQ1: exchange with operand bit 0 set enters compact
// RQ2: exchange with bit 0 clear enters wide
// RQ3: exception enters wide, links, jumps to vector
// RQ4: exception return restores compact state
// RQ5: state switch keeps mode and registers
// RQ6: wide 32-bit word fetch, compact halfword fetch
// RQ7: memory is bytes upward, four per word
// RQ8: big endian lowest byte on lines 31:24
// RQ9: little endian lowest byte on lines 7:0
// RQ10: byte, halfword, word data, natural alignment
// RQ11: seven modes, all but user privileged
// RQ12: 31 general plus six status registers
// RQ13: sixteen visible registers, banked in privilege
// RQ14: link copies program counter into register 14
// RQ15: banked link takes return address
// RQ16: program counter low bits read zero
// RQ17: fast interrupt banks registers 8 to 14
// RQ18: four modes bank registers 13 and 14
// RQ19: compact low registers and status shared
// RQ20: compact high registers via special variants
// RQ21: one current, five saved status words
// RQ22: flags updated; compact tests only branches
// RQ23: low eight status bits are control bits
// RQ24: five-bit mode codes, others illegal
// RQ25: register ports select bank combinationally
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module brf_core
  import brf_pkg::*;
(
  input wire logic aclk, // Core clock, 250 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [3:0] rd_a_idx, // Read port A register index
  output logic [31:0] rd_a_data, // Read port A value
  input wire logic [3:0] rd_b_idx, // Read port B register index
  output logic [31:0] rd_b_data, // Read port B value
  input wire logic hi_access, // Special variant may touch 8..15
  output logic hi_refused, // Compact access to 8..15 refused
  input wire brf_wr_t wr_req, // Datapath register write
  input wire logic bx_valid, // Branch_exchange executes
  input wire logic [31:0] bx_operand, // Branch_exchange operand
  input wire logic bl_valid, // Branch_with_link executes
  input wire logic [31:0] bl_target, // Branch_with_link target
  input wire logic pc_advance, // Step to next instruction
  input wire brf_exc_t exc_req, // Exception entry
  input wire logic ret_valid, // Exception return
  input wire logic [31:0] ret_pc, // Return address
  input wire logic flags_we, // Condition flags update
  input wire logic [3:0] flags_in, // New N, Z, C, V
  input wire logic msr_valid, // Status word write from software
  input wire logic [31:0] msr_data, // Status word write value
  input wire logic is_branch, // Current instruction is a branch
  output logic cond_allowed, // Condition test permitted
  output logic [31:0] cpsr, // Current status word
  output logic [31:0] fetch_addr, // Aligned fetch address
  output logic fetch_half_hi, // Upper halfword selected
  output logic compact_state, // Compact instruction state
  output logic privileged, // Mode other than user
  output logic illegal_mode, // Mode field holds no legal code
  input wire brf_mem_t st_req, // Store data and address
  output logic [31:0] st_lanes, // Store data on bus lanes
  output logic [3:0] st_be, // Store byte enables
  output logic misaligned, // Access breaks natural alignment
  input wire logic [31:0] ld_bus, // Load data from bus lanes
  output logic [31:0] ld_data, // Load data, right aligned
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read valid
  input wire logic s_axi_rready // AXI read ready
);

  // RQ24 mode code check
  function automatic logic is_legal(input logic [4:0] m);
    return m == MODE_USR || m == MODE_FIQ || m == MODE_IRQ ||
           m == MODE_SVC || m == MODE_ABT || m == MODE_UND ||
           m == MODE_SYS;
  endfunction : is_legal

  // RQ17 RQ18 architectural index to physical slot
  function automatic logic [4:0] phys_idx(input logic [3:0] idx,
                                          input logic [4:0] m);
    logic [4:0] sp;
    sp = PHYS_USR_SP;
    case (m)
      MODE_FIQ: sp = PHYS_FIQ_SP;
      MODE_IRQ: sp = PHYS_IRQ_SP;
      MODE_SVC: sp = PHYS_SVC_SP;
      MODE_ABT: sp = PHYS_ABT_SP;
      MODE_UND: sp = PHYS_UND_SP;
      default: sp = PHYS_USR_SP;
    endcase
    if (idx == 4'hF) return PHYS_PC;
    if (idx < 4'h8) return {1'b0, idx};
    if (idx < 4'hD) begin
      if (m == MODE_FIQ) return PHYS_FIQ_HI + {1'b0, idx} - 5'h08;
      return {1'b0, idx};
    end
    return sp + {4'h0, idx[1]};
  endfunction : phys_idx

  // RQ21 saved status word slot of a mode
  function automatic logic [2:0] saved_status_word_idx(input logic [4:0] m);
    case (m)
      MODE_FIQ: return 3'h0;
      MODE_IRQ: return 3'h1;
      MODE_SVC: return 3'h2;
      MODE_ABT: return 3'h3;
      MODE_UND: return 3'h4;
      default: return SAVED_STATUS_WORD_NONE;
    endcase
  endfunction : saved_status_word_idx

  // RQ8 RQ9 bit shift of the least significant byte of an access
  function automatic logic [4:0] lane_shift(input logic [1:0] a,
                                            input logic [1:0] sz,
                                            input logic big);
    logic [2:0] nb;
    logic [2:0] off;
    nb = (sz == SIZE_BYTE) ? 3'h1 : (sz == SIZE_HALF) ? 3'h2 : 3'h4;
    off = 3'h4 - {1'b0, a} - nb;
    return big ? {off[1:0], 3'h0} : {a, 3'h0};
  endfunction : lane_shift

  // RQ12 thirty general slots plus the program counter; six status words
  logic [31:0] phys_q [NUM_PHYS];
  logic [31:0] pc_q;
  logic [31:0] cpsr_q;
  logic [31:0] cpsr_d;
  logic [31:0] saved_status_word_q [NUM_SAVED_STATUS_WORD];
  logic [31:0] ctrl_q;
  logic [31:0] pc_d;
  logic [4:0] cur_mode;
  logic [2:0] cur_saved_status_word;
  logic [31:0] pc_view;
  logic [31:0] step;
  logic exc_ok;
  logic ret_ok;
  logic wr_ok;
  logic [4:0] wr_phys;
  logic [4:0] bl_phys;
  logic [4:0] exc_phys;
  logic big_endian;

  assign cur_mode = cpsr_q[4:0];
  assign cur_saved_status_word = saved_status_word_idx(cur_mode);
  assign compact_state = cpsr_q[PSR_T_BIT];
  assign big_endian = ctrl_q[CTRL_BIG_BIT];
  assign cpsr = cpsr_q;
  assign step = compact_state ? COMPACT_STEP : WIDE_STEP;

  // RQ16 program counter low bits forced to zero by state
  assign pc_view = compact_state ? {pc_q[31:1], 1'b0}
                                 : {pc_q[31:2], 2'h0};
  // RQ6 fetch alignment and halfword select
  assign fetch_addr = pc_view;
  assign fetch_half_hi = compact_state & pc_q[1];

  // RQ11 privilege and legality of the current mode
  assign privileged = cur_mode != MODE_USR;
  assign illegal_mode = !is_legal(cur_mode);

  // RQ22 compact state lets only branches test flags
  assign cond_allowed = !compact_state || is_branch;

  // Requests that reach state; exceptions into user or system are ignored
  assign exc_ok = exc_req.valid && saved_status_word_idx(exc_req.mode) != SAVED_STATUS_WORD_NONE;
  assign ret_ok = ret_valid && cur_saved_status_word != SAVED_STATUS_WORD_NONE;

  // RQ20 compact state reaches 8..15 only through special variants
  assign hi_refused = compact_state && !hi_access &&
                      (rd_a_idx[3] || rd_b_idx[3] ||
                       (wr_req.en && wr_req.idx[3]));
  assign wr_ok = wr_req.en &&
                 !(compact_state && !hi_access && wr_req.idx[3]);

  assign wr_phys = phys_idx(wr_req.idx, cur_mode);
  // RQ14 link lands in register 14 of the running mode
  assign bl_phys = phys_idx(4'hE, cur_mode);
  // RQ15 exception link lands in the target mode's bank
  assign exc_phys = phys_idx(4'hE, exc_req.mode);

  // RQ25 RQ13 RQ19 read ports decode bank from the live mode
  always_comb begin
    logic [4:0] pa;
    logic [4:0] pb;
    pa = phys_idx(rd_a_idx, cur_mode);
    pb = phys_idx(rd_b_idx, cur_mode);
    rd_a_data = (pa == PHYS_PC) ? pc_view : phys_q[pa];
    rd_b_data = (pb == PHYS_PC) ? pc_view : phys_q[pb];
  end

  // Physical general registers, one flop group per slot
  // RQ5 slots change only on a write or a link, never on a state switch
  generate
    for (genvar i = 0; i < NUM_PHYS; i++) begin : g_phys
      logic hit_exc;
      logic hit_bl;
      logic hit_wr;
      assign hit_exc = exc_ok && exc_phys == 5'(i);
      assign hit_bl = !exc_ok && bl_valid && bl_phys == 5'(i);
      assign hit_wr = wr_ok && wr_phys == 5'(i);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          phys_q[i] <= 32'h00000000;
        end else if (hit_exc) begin
          phys_q[i] <= exc_req.ret_pc;
        end else if (hit_bl) begin
          phys_q[i] <= pc_view + step;
        end else if (hit_wr) begin
          phys_q[i] <= wr_req.data;
        end
      end
    end
  endgenerate

  // Program counter next value; exception beats every other source
  always_comb begin
    pc_d = pc_q;
    if (exc_ok) begin
      // RQ3 fetch restarts at the vector
      pc_d = exc_req.vector;
    end else if (ret_ok) begin
      pc_d = ret_pc;
    end else if (bx_valid) begin
      pc_d = {bx_operand[31:1], 1'b0};
    end else if (bl_valid) begin
      pc_d = bl_target;
    end else if (wr_ok && wr_phys == PHYS_PC) begin
      pc_d = wr_req.data;
    end else if (pc_advance) begin
      pc_d = pc_q + step;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // RQ23 current status word: flags above, control bits in the low byte
  always_comb begin
    cpsr_d = cpsr_q;
    if (exc_ok) begin
      // RQ3 exception forces wide state, mode and the IRQ mask; the FIQ mask is set only on FIQ entry, else kept
      cpsr_d[PSR_CTRL_TOP:0] = {1'b1,
                                cpsr_q[PSR_F_BIT] ||
                                exc_req.mode == MODE_FIQ,
                                1'b0, exc_req.mode};
    end else if (ret_ok) begin
      // RQ4 return restores the saved state bit with the rest
      cpsr_d = saved_status_word_q[cur_saved_status_word];
    end else begin
      // RQ1 RQ2 operand bit 0 picks the state
      if (bx_valid) cpsr_d[PSR_T_BIT] = bx_operand[0];
      // RQ22 flags follow the datapath
      if (flags_we) cpsr_d[PSR_N_BIT:PSR_V_BIT] = flags_in;
      if (msr_valid) begin
        cpsr_d[PSR_N_BIT:PSR_V_BIT] = msr_data[PSR_N_BIT:PSR_V_BIT];
        // Control bits only in privilege; the state bit is never
        // software's, and an illegal mode code is dropped
        if (privileged && is_legal(msr_data[4:0])) begin
          cpsr_d[PSR_I_BIT] = msr_data[PSR_I_BIT];
          cpsr_d[PSR_F_BIT] = msr_data[PSR_F_BIT];
          cpsr_d[4:0] = msr_data[4:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpsr_q <= CPSR_RST;
    end else begin
      cpsr_q <= cpsr_d;
    end
  end

  // RQ21 saved status words capture the old word on exception entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NUM_SAVED_STATUS_WORD; k++) saved_status_word_q[k] <= 32'h00000000;
    end else if (exc_ok) begin
      saved_status_word_q[saved_status_word_idx(exc_req.mode)] <= cpsr_q;
    end
  end

  // RQ7 RQ10 alignment: halfwords even, words on four-byte bounds
  assign misaligned = (st_req.size == SIZE_HALF && st_req.addr[0]) ||
                      (st_req.size == SIZE_WORD && st_req.addr != 2'h0);

  // RQ8 RQ9 byte lane steering for stores and loads
  always_comb begin
    logic [4:0] sh;
    logic [3:0] nbm;
    logic [31:0] raw;
    sh = lane_shift(st_req.addr, st_req.size, big_endian);
    nbm = (st_req.size == SIZE_BYTE) ? 4'h1 :
          (st_req.size == SIZE_HALF) ? 4'h3 : 4'hF;
    st_lanes = st_req.data << sh;
    st_be = misaligned ? 4'h0 : nbm << sh[4:3];
    raw = ld_bus >> sh;
    ld_data = (st_req.size == SIZE_BYTE) ? {24'h0, raw[7:0]} :
              (st_req.size == SIZE_HALF) ? {16'h0, raw[15:0]} : raw;
  end

  // Register bus: address and data held until both are in
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (aw_have_q && w_have_q) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (aw_have_q && w_have_q) begin
      w_have_q <= 1'b0;
    end
  end

  // Write commit: only the control register is writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (aw_have_q && w_have_q) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_q == OFF_CTRL) begin
        s_axi_bresp <= RESP_OKAY;
        if (w_strb_q[0]) ctrl_q[CTRL_BIG_BIT] <= w_data_q[CTRL_BIG_BIT];
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: s_axi_rdata <= ctrl_q;
        OFF_CPSR: s_axi_rdata <= cpsr_q;
        OFF_PC: s_axi_rdata <= pc_view;
        OFF_SAVED_STATUS_WORD: begin
          s_axi_rdata <= (cur_saved_status_word == SAVED_STATUS_WORD_NONE) ? 32'h00000000
                                                 : saved_status_word_q[cur_saved_status_word];
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the block's own state
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_bx_only;
    bx_valid && !exc_ok && !ret_ok;
  endsequence

  sequence s_exc_enter;
    exc_ok;
  endsequence

  sequence s_ret_only;
    ret_ok && !exc_ok;
  endsequence

  a_bx_sets_compact: assert property ( // RQ1
    s_bx_only ##0 bx_operand[0] |=> compact_state)
    else $error("exchange with bit 0 set did not enter compact");
  a_bx_sets_wide: assert property ( // RQ2
    s_bx_only ##0 !bx_operand[0] |=> !compact_state)
    else $error("exchange with bit 0 clear did not enter wide");
  a_exc_entry_state: assert property ( // RQ3
    s_exc_enter |=> !compact_state && pc_q == $past(exc_req.vector) &&
                    cur_mode == $past(exc_req.mode) && cpsr_q[PSR_I_BIT])
    else $error("exception entry state wrong");
  a_exc_return_state: assert property ( // RQ4
    s_ret_only |=>
      compact_state == $past(saved_status_word_q[cur_saved_status_word][PSR_T_BIT]))
    else $error("return did not restore saved state bit");
  a_state_keeps_mode: assert property ( // RQ5
    s_bx_only ##0 !msr_valid |=> $stable(cur_mode))
    else $error("state switch changed the mode");
  a_pc_low_zero: assert property ( // RQ16
    (compact_state -> fetch_addr[0] == 1'b0) &&
    (!compact_state -> fetch_addr[1:0] == 2'h0 && !fetch_half_hi))
    else $error("program counter low bits not zero");
  a_bl_link_value: assert property ( // RQ14
    bl_valid && !exc_ok && !ret_ok && !bx_valid && !msr_valid &&
    !(wr_ok && wr_req.idx == 4'hE) |=>
      phys_q[phys_idx(4'hE, cur_mode)] == $past(pc_view + step))
    else $error("link register missed the return address");
  a_big_lane_low: assert property ( // RQ8
    big_endian && st_req.size == SIZE_BYTE && st_req.addr == 2'h0 |->
      st_be == 4'h8 && st_lanes[31:24] == st_req.data[7:0])
    else $error("big endian byte 0 not on lines 31:24");
  a_little_lane_low: assert property ( // RQ9
    !big_endian && st_req.size == SIZE_BYTE && st_req.addr == 2'h0 |->
      st_be == 4'h1 && st_lanes[7:0] == st_req.data[7:0])
    else $error("little endian byte 0 not on lines 7:0");
  a_saved_status_word_capture: assert property ( // RQ21
    s_exc_enter |=> saved_status_word_q[saved_status_word_idx(cur_mode)] == $past(cpsr_q))
    else $error("saved status word not captured");
  a_mode_stays_legal: assert property ( // RQ24
    s_exc_enter |=> !illegal_mode && privileged)
    else $error("exception left an illegal mode");
  a_compact_cond_gate: assert property ( // RQ22
    compact_state && !is_branch |-> !cond_allowed)
    else $error("compact non-branch allowed a condition test");

endmodule : brf_core

// File: hdl/brf_pkg.sv
// Package for the banked register file and processor state block
package brf_pkg;
  // Mode field codes
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;
  localparam logic [4:0] MODE_SYS = 5'h1F;
  // Status word bit positions
  localparam int PSR_N_BIT = 31;
  localparam int PSR_V_BIT = 28;
  localparam int PSR_I_BIT = 7;
  localparam int PSR_F_BIT = 6;
  localparam int PSR_T_BIT = 5;
  localparam int PSR_CTRL_TOP = 7;
  // Values after reset: supervisor, both interrupts off, wide state
  localparam logic [31:0] CPSR_RST = 32'h000000D3;
  localparam logic [31:0] PC_RST = 32'h00000000;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  // Physical storage layout
  localparam int NUM_PHYS = 30;
  localparam int NUM_SAVED_STATUS_WORD = 5;
  localparam logic [4:0] PHYS_PC = 5'h1F;
  localparam logic [4:0] PHYS_FIQ_HI = 5'h0D;
  localparam logic [4:0] PHYS_USR_SP = 5'h12;
  localparam logic [4:0] PHYS_FIQ_SP = 5'h14;
  localparam logic [4:0] PHYS_IRQ_SP = 5'h16;
  localparam logic [4:0] PHYS_SVC_SP = 5'h18;
  localparam logic [4:0] PHYS_ABT_SP = 5'h1A;
  localparam logic [4:0] PHYS_UND_SP = 5'h1C;
  localparam logic [2:0] SAVED_STATUS_WORD_NONE = 3'h7;
  // Program counter steps per state
  localparam logic [31:0] WIDE_STEP = 32'h00000004;
  localparam logic [31:0] COMPACT_STEP = 32'h00000002;
  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // Register bus offsets and answers
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CPSR = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_SAVED_STATUS_WORD = 8'h0C;
  localparam int CTRL_BIG_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } brf_wr_t;

  typedef struct packed {
    logic valid;
    logic [4:0] mode;
    logic [31:0] vector;
    logic [31:0] ret_pc;
  } brf_exc_t;

  typedef struct packed {
    logic [1:0] size;
    logic [1:0] addr;
    logic [31:0] data;
  } brf_mem_t;
endpackage : brf_pkg

// File: tb/brf_dp_model.sv
// Datapath stand-in that turns bench commands into requests
`timescale 1ns/1ps
module brf_dp_model
  import brf_pkg::*;
(
  input wire logic [2:0] cmd, // 1 wr 2 bx 3 bl 4 adv 5 exc 6 ret 7 flg
  input wire logic [31:0] arg, // Operand, target or vector
  input wire logic [4:0] md, // Exception mode; nonzero makes 7 a status write
  input wire logic [3:0] wi, // Written register index
  output brf_wr_t wr_req, // Register write
  output logic bx_valid, // Exchange
  output logic [31:0] bx_operand, // Exchange operand
  output logic bl_valid, // Link branch
  output logic [31:0] bl_target, // Link target
  output logic pc_advance, // Next instruction
  output brf_exc_t exc_req, // Exception entry
  output logic ret_valid, // Exception return
  output logic [31:0] ret_pc, // Return address
  output logic flags_we, // Flag update
  output logic [3:0] flags_in, // New N, Z, C, V
  output logic msr_valid, // Status write from software
  output logic [31:0] msr_data // Status write value
);
  // Operands follow arg, so a stale value is never reused
  always_comb begin
    wr_req = '{cmd == 3'h1, wi, arg};
    bx_valid = cmd == 3'h2;
    bx_operand = arg;
    bl_valid = cmd == 3'h3;
    bl_target = arg;
    pc_advance = cmd == 3'h4;
    exc_req = '{cmd == 3'h5, md, arg, ~arg}; // Link is inverted vector
    ret_valid = cmd == 3'h6;
    ret_pc = arg;
    flags_we = cmd == 3'h7 && md == 5'h00;
    flags_in = arg[3:0];
    // Code 7 with a nonzero mode field is a software status write
    msr_valid = cmd == 3'h7 && md != 5'h00;
    msr_data = arg;
  end
endmodule : brf_dp_model

// File: tb/test_brf_core.sv
// Self-checking bench for the banked register file block
`timescale 1ns/1ps
module test_brf_core;
  import brf_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, hi_access = 1'h0, is_branch = 1'h0;
  logic [3:0] rd_a_idx = 4'h0, rd_b_idx = 4'h0, wi = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] cmd = 3'h0;
  logic [4:0] md = 5'h0;
  logic [31:0] arg = 32'h0, ld_bus = 32'h0, s_axi_wdata = 32'h0;
  brf_mem_t st_req = '0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] rd_a_data, rd_b_data, cpsr, fetch_addr, st_lanes, ld_data;
  logic [31:0] s_axi_rdata, bx_operand, bl_target, ret_pc, msr_data;
  logic hi_refused, cond_allowed, fetch_half_hi, compact_state, privileged;
  logic illegal_mode, misaligned, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, bx_valid, bl_valid, pc_advance;
  logic ret_valid, flags_we, msr_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] st_be, flags_in;
  brf_wr_t wr_req;
  brf_exc_t exc_req;
  int n_fail = 0, checked = 0, k, j;
  logic [31:0] v, w, a, p;
  logic [4:0] modes [4] = '{MODE_FIQ, MODE_IRQ, MODE_ABT, MODE_UND};

  brf_core i_dut (.*);
  brf_dp_model i_dp (.*);

  always #2 aclk = ~aclk;

  task chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  // One request held for one edge; results looked at once settled
  task op(input logic [2:0] c, input logic [31:0] d, input logic [4:0] m,
          input logic [3:0] i);
    @(posedge aclk);
    cmd <= c;
    arg <= d;
    md <= m;
    wi <= i;
    @(posedge aclk);
    cmd <= 3'h0;
    #1;
  endtask : op

  // Both read ports must agree with the expected value
  task rx(input logic [3:0] i, input logic [31:0] x);
    @(posedge aclk);
    rd_a_idx <= i;
    rd_b_idx <= i;
    #1;
    chk(rd_a_data, x);
    chk(rd_b_data, x);
  endtask : rx

  // Address and data offered together, each dropped when taken
  task axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, r);
  endtask : axw

  task axr(input logic [7:0] ad, input logic [31:0] x, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, x);
    chk(s_axi_rresp, r);
  endtask : axr

  task end_of_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Whole run needs about 110 cycles; a hang ends here
  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end

  initial begin
    v = $urandom(21271);
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    #1;
    chk(cpsr, CPSR_RST);
    axr(OFF_CPSR, CPSR_RST, RESP_OKAY);
    axr(8'h40, 32'h0, RESP_SLVERR);
    axw(OFF_PC, $urandom, RESP_SLVERR);
    $display("test reset done");
    v = $urandom;
    a = $urandom | 32'h1;
    op(3'h1, v, 5'h0, 4'h3);
    op(3'h2, a, 5'h0, 4'h0);
    chk(compact_state, 1'h1);
    chk(cpsr[4:0], MODE_SVC);
    chk(fetch_half_hi, a[1]);
    chk(cond_allowed, 1'h0);
    rx(4'h3, v);
    rx(4'hF, a & ~32'h1);
    $display("test exchange done");
    a = $urandom & ~32'h3;
    op(3'h5, a, MODE_IRQ, 4'h0);
    chk(cpsr[7:0], 8'hD2);
    rx(4'hE, ~a);
    rx(4'hF, a);
    axr(OFF_SAVED_STATUS_WORD, 32'hF3, RESP_OKAY);
    p = $urandom & ~32'h1;
    op(3'h6, p, 5'h0, 4'h0);
    chk(cpsr, 32'hF3);
    rx(4'hF, p);
    $display("test exception done");
    // High write in compact state without the special variant is dropped
    op(3'h1, v, 5'h0, 4'h8);
    rx(4'h8, 32'h0);
    chk(hi_refused, 1'h1);
    // The special variant may reach the high registers
    @(posedge aclk);
    hi_access <= 1'h1;
    op(3'h1, p, 5'h0, 4'h8);
    rx(4'h8, p);
    chk(hi_refused, 1'h0);
    op(3'h2, 32'h0, 5'h0, 4'h0);
    chk(compact_state, 1'h0);
    op(3'h1, v, 5'h0, 4'h8);
    op(3'h1, ~v, 5'h0, 4'hD);
    for (k = 0; k < 4; k++) begin
      op(3'h5, a, modes[k], 4'h0);
      chk(privileged, 1'h1);
      rx(4'hD, 32'h0);
      rx(4'h8, (modes[k] == MODE_FIQ) ? 32'h0 : v);
      op(3'h1, a, 5'h0, 4'hD);
      op(3'h6, a, 5'h0, 4'h0);
    end
    op(3'h5, a, MODE_USR, 4'h0);
    chk(cpsr[4:0], MODE_SVC);
    rx(4'hD, ~v);
    rx(4'h8, v);
    $display("test banking done");
    w = $urandom & ~32'h3;
    op(3'h3, w, 5'h0, 4'h0);
    rx(4'hE, a + 32'h4);
    op(3'h4, 32'h0, 5'h0, 4'h0);
    rx(4'hF, w + 32'h4);
    chk(fetch_addr, w + 32'h4);
    op(3'h7, v, 5'h0, 4'h0);
    chk(cpsr[31:28], v[3:0]);
    chk(cond_allowed, 1'h1);
    // Software status writes: state bit kept, illegal mode dropped
    op(3'h7, 32'h500000FF, 5'h1, 4'h0);
    chk(cpsr, 32'h500000DF);
    op(3'h7, 32'h00000005, 5'h1, 4'h0);
    chk(cpsr, 32'h000000DF);
    chk(illegal_mode, 1'h0);
    op(3'h7, 32'h00000010, 5'h1, 4'h0);
    chk(privileged, 1'h0);
    $display("test link done");
    // First four bytes in big endian, then four in little endian
    axw(OFF_CTRL, 32'h1, RESP_OKAY);
    axr(OFF_CTRL, 32'h1, RESP_OKAY);
    for (k = 0; k < 8; k++) begin
      if (k == 4) axw(OFF_CTRL, 32'h0, RESP_OKAY);
      v = $urandom;
      w = $urandom;
      j = (k < 4) ? 3 - k : k - 4;
      @(posedge aclk);
      st_req <= '{SIZE_BYTE, k[1:0], v};
      ld_bus <= w;
      #1;
      chk(st_be, 4'h1 << j);
      chk(st_lanes & (32'hFF << 8 * j), (v & 32'hFF) << 8 * j);
      chk(ld_data, (w >> 8 * j) & 32'hFF);
    end
    @(posedge aclk);
    st_req <= '{SIZE_WORD, 2'h2, v};
    #1;
    chk(misaligned, 1'h1);
    chk(st_be, 4'h0);
    $display("test lanes done");
    end_of_test;
  end
endmodule : test_brf_core
